// [verilog/reset_timeout_sequencer.sv]
// Purpose: reset and start-up time-out sequencer with Avalon-MM registers
// Assumes: pins are asynchronous; sleep and wake requests come from clk_sys logic
// Notes:   power-up timer counts clk_sys in place of the internal rc clock
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_cfg.svh"
module reset_timeout_sequencer #(
  parameter int PWRUP_CYC = `PWRUP_TIME_US * `CLK_MHZ,
  parameter int PLL_CYC   = `PLL_TIME_US * `CLK_MHZ,
  parameter int BRN_CYC   = `BRN_MIN_TIME_US * `CLK_MHZ,
  parameter int OSCSU_CYC = `OSCSU_CYCLES,
  parameter int CW        = 24
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // supply monitor and pins
  input  wire logic        porPulse,
  input  wire logic        supplyBelow,
  input  wire logic        masterClearPin_b,
  input  wire logic        oscInputPin,
  // power management requests
  input  wire logic        sleepReq,
  input  wire logic        wakeReq,
  // reset outputs
  output logic             chipReset,
  output logic             execHold
);

  // largest count must fit the shared timer
  if (CW < $clog2(PWRUP_CYC + 1) || CW < $clog2(PLL_CYC + 1) ||
      CW < $clog2(BRN_CYC + 1) || CW < $clog2(OSCSU_CYC + 1) ||
      PWRUP_CYC < 1 || PLL_CYC < 1 || BRN_CYC < 1 || OSCSU_CYC < 1) begin : g_bad_cfg
    $error("reset_timeout_sequencer counts do not fit CW");
  end

  localparam logic [CW-1:0] LIM_PWRUP = CW'(PWRUP_CYC);
  localparam logic [CW-1:0] LIM_PLL   = CW'(PLL_CYC);
  localparam logic [CW-1:0] LIM_OSCSU = CW'(OSCSU_CYC);
  localparam logic [CW-1:0] LIM_BRN   = CW'(BRN_CYC);

  logic                    rstMeta_b_r;
  logic                    rstSync_b_r;
  logic [3:0]              pinSync;
  logic                    porS;
  logic                    belowS;
  logic                    mclrLow;
  logic                    oscS;
  logic                    oscPrev_r;
  logic                    oscRise;
  rst_seq_pkg::cfg_t       cfg_r;
  rst_seq_pkg::seq_state_t state_r;
  rst_seq_pkg::seq_state_t state_nxt;
  logic                    porPath_r;
  logic [CW-1:0]           brnCnt_r;
  logic                    brnTrip;
  logic                    isCrystal;
  logic [CW-1:0]           limit;
  logic                    tick;
  logic                    timerDone;
  logic                    holdReset;
  logic                    waitReq_r;
  logic                    accept;
  logic [2:0]              flags_r;
  logic [31:0]             rdMux;

  // reset release through two flops, asserted at once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b_r <= 1'b0;
      rstSync_b_r <= 1'b0;
    end else begin
      rstMeta_b_r <= 1'b1;
      rstSync_b_r <= rstMeta_b_r;
    end
  end

  // pin levels into the clk_sys domain
  sync_2ff #(
    .W (4)
  ) u_pin_sync (
    .clk   (clk_sys),
    .rst_b (rstSync_b_r),
    .d     ({porPulse, supplyBelow, ~masterClearPin_b, oscInputPin}),
    .q     (pinSync)
  );

  assign porS    = pinSync[3];
  assign belowS  = pinSync[2];
  assign mclrLow = pinSync[1];
  assign oscS    = pinSync[0];

  // oscillator edges seen after synchronisation; pin must run below clk_sys/2
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      oscPrev_r <= 1'b0;
    end else begin
      oscPrev_r <= oscS;
    end
  end

  assign oscRise = oscS && !oscPrev_r;

  assign isCrystal = (cfg_r.oscMode != rst_seq_pkg::OSC_RESCAP);

  // brown-out dip filter: only a dip lasting at least the minimum trips
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      brnCnt_r <= '0;
    end else if (!(cfg_r.brnEn && belowS)) begin
      brnCnt_r <= '0;
    end else if (brnCnt_r != LIM_BRN) begin
      brnCnt_r <= brnCnt_r + 1'b1;
    end
  end

  assign brnTrip = (brnCnt_r == LIM_BRN);

  // next stage of the time-out sequence
  always_comb begin
    state_nxt = state_r;
    if (porS) begin
      state_nxt = rst_seq_pkg::ST_POR;
    end else if (brnTrip && state_r != rst_seq_pkg::ST_BROWN) begin
      state_nxt = rst_seq_pkg::ST_BROWN;
    end else begin
      case (state_r)
        rst_seq_pkg::ST_POR: begin
          if (cfg_r.pwrupEn) begin
            state_nxt = rst_seq_pkg::ST_PWRUP;
          end else if (isCrystal) begin
            state_nxt = rst_seq_pkg::ST_OSCSU;
          end else if (cfg_r.pllEn) begin
            state_nxt = rst_seq_pkg::ST_PLLWAIT;
          end else begin
            state_nxt = rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_PWRUP: begin
          if (cfg_r.brnEn && belowS) begin
            state_nxt = rst_seq_pkg::ST_BROWN;
          end else if (timerDone) begin
            if (porPath_r && isCrystal) begin
              state_nxt = rst_seq_pkg::ST_OSCSU;
            end else if (porPath_r && cfg_r.pllEn) begin
              state_nxt = rst_seq_pkg::ST_PLLWAIT;
            end else begin
              state_nxt = rst_seq_pkg::ST_RUN;
            end
          end
        end
        rst_seq_pkg::ST_OSCSU: begin
          if (timerDone) begin
            if (porPath_r && cfg_r.pllEn) begin
              state_nxt = rst_seq_pkg::ST_PLLWAIT;
            end else begin
              state_nxt = rst_seq_pkg::ST_RUN;
            end
          end
        end
        rst_seq_pkg::ST_PLLWAIT: begin
          if (timerDone) begin
            state_nxt = rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_BROWN: begin
          if (!belowS || !cfg_r.brnEn) begin
            state_nxt = cfg_r.pwrupEn ? rst_seq_pkg::ST_PWRUP
                                      : rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_RUN: begin
          if (sleepReq) begin
            state_nxt = rst_seq_pkg::ST_SLEEP;
          end
        end
        rst_seq_pkg::ST_SLEEP: begin
          if (wakeReq) begin
            state_nxt = isCrystal ? rst_seq_pkg::ST_OSCSU
                                  : rst_seq_pkg::ST_RUN;
          end
        end
        default: begin
          state_nxt = rst_seq_pkg::ST_POR;
        end
      endcase
    end
  end

  // state register; power-on is the reset state
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      state_r <= rst_seq_pkg::ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // remembers whether the sequence began at power-on
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      porPath_r <= 1'b1;
    end else if (state_nxt == rst_seq_pkg::ST_POR) begin
      porPath_r <= 1'b1;
    end else if (state_nxt == rst_seq_pkg::ST_BROWN || state_nxt == rst_seq_pkg::ST_SLEEP) begin
      porPath_r <= 1'b0;
    end
  end

  // one timer serves every stage; the pll wait reuses the power-up counter
  always_comb begin
    limit = LIM_PWRUP;
    tick  = 1'b1;
    case (state_r)
      rst_seq_pkg::ST_OSCSU: begin
        limit = LIM_OSCSU;
        tick  = oscRise;
      end
      rst_seq_pkg::ST_PLLWAIT: begin
        limit = LIM_PLL;
      end
      default: begin
        limit = LIM_PWRUP;
      end
    endcase
  end

  stage_timer #(
    .W (CW)
  ) u_timer (
    .clk   (clk_sys),
    .rst_b (rstSync_b_r),
    .clear (state_nxt != state_r),
    .tick  (tick),
    .limit (limit),
    .done  (timerDone)
  );

  // reset reasons; the pin only gates, the time-outs run on regardless
  assign holdReset = mclrLow ||
                     state_r == rst_seq_pkg::ST_POR ||
                     state_r == rst_seq_pkg::ST_BROWN ||
                     state_r == rst_seq_pkg::ST_PWRUP ||
                     (porPath_r && (state_r == rst_seq_pkg::ST_OSCSU ||
                                    state_r == rst_seq_pkg::ST_PLLWAIT));

  // registered reset outputs
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      chipReset <= 1'b1;
      execHold  <= 1'b1;
    end else begin
      chipReset <= holdReset;
      execHold  <= holdReset || state_r != rst_seq_pkg::ST_RUN;
    end
  end

  // bus handshake: one wait cycle, then the access completes
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      waitReq_r <= 1'b1;
    end else if (waitReq_r && (avs_read || avs_write)) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  assign accept          = !waitReq_r && (avs_read || avs_write);
  assign avs_waitrequest = waitReq_r;

  // configuration settings, written through byte lane 0
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      cfg_r.pwrupEn <= `RST_PWRUP_EN;
      cfg_r.brnEn   <= `RST_BRN_EN;
      cfg_r.pllEn   <= `RST_PLL_EN;
      cfg_r.oscMode <= rst_seq_pkg::osc_mode_t'(`RST_OSC_MODE);
    end else if (accept && avs_write && avs_address == `ADDR_CTRL && avs_byteenable[0]) begin
      cfg_r.pwrupEn <= avs_writedata[`CTRL_PWRUP_BIT];
      cfg_r.brnEn   <= avs_writedata[`CTRL_BRN_BIT];
      cfg_r.pllEn   <= avs_writedata[`CTRL_PLL_BIT];
      cfg_r.oscMode <= rst_seq_pkg::osc_mode_t'(avs_writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    end
  end

  // sticky causes; a new event wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      flags_r <= 3'h1;
    end else begin
      flags_r[`FLAG_POR_BIT]    <= porS ||
        (flags_r[`FLAG_POR_BIT] && !(accept && avs_write &&
         avs_address == `ADDR_FLAG && avs_byteenable[0] && avs_writedata[`FLAG_POR_BIT]));
      flags_r[`FLAG_BRN_BIT]    <= brnTrip ||
        (flags_r[`FLAG_BRN_BIT] && !(accept && avs_write &&
         avs_address == `ADDR_FLAG && avs_byteenable[0] && avs_writedata[`FLAG_BRN_BIT]));
      flags_r[`FLAG_MCLEAR_BIT] <= mclrLow ||
        (flags_r[`FLAG_MCLEAR_BIT] && !(accept && avs_write &&
         avs_address == `ADDR_FLAG && avs_byteenable[0] && avs_writedata[`FLAG_MCLEAR_BIT]));
    end
  end

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0;
    case (avs_address)
      `ADDR_CTRL: begin
        rdMux[`CTRL_PWRUP_BIT]               = cfg_r.pwrupEn;
        rdMux[`CTRL_BRN_BIT]                 = cfg_r.brnEn;
        rdMux[`CTRL_PLL_BIT]                 = cfg_r.pllEn;
        rdMux[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = cfg_r.oscMode;
      end
      `ADDR_STAT: begin
        rdMux[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_r;
        rdMux[`STAT_CHIPRST_BIT]               = chipReset;
        rdMux[`STAT_BELOW_BIT]                 = belowS;
        rdMux[`STAT_MCLEAR_BIT]                = mclrLow;
      end
      `ADDR_FLAG: begin
        rdMux[2:0] = flags_r;
      end
      default: begin
        rdMux = 32'h0;
      end
    endcase
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk_sys or negedge rstSync_b_r) begin
    if (!rstSync_b_r) begin
      avs_readdata <= 32'h0;
    end else if (waitReq_r && avs_read) begin
      avs_readdata <= rdMux;
    end
  end

  // pin low forces reset on the next edge
  property p_master_clear_pin_reset;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    mclrLow |=> chipReset;
  endproperty
  a_master_clear_pin_reset: assert property (p_master_clear_pin_reset) else $error("reset not held for pin low");

  // power-up stage after power-on always holds reset
  property p_pwrup_holds;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    state_r == rst_seq_pkg::ST_PWRUP |=> chipReset;
  endproperty
  a_pwrup_holds: assert property (p_pwrup_holds) else $error("reset dropped in power-up delay");

  // a disabled delay is never entered
  property p_pwrup_skip;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r != rst_seq_pkg::ST_PWRUP && !cfg_r.pwrupEn) |=> state_r != rst_seq_pkg::ST_PWRUP;
  endproperty
  a_pwrup_skip: assert property (p_pwrup_skip) else $error("disabled delay entered");

  // start-up stage leaves only once the count is met
  property p_oscsu_count;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r == rst_seq_pkg::ST_OSCSU && !timerDone && !porS && !brnTrip)
      |=> state_r == rst_seq_pkg::ST_OSCSU;
  endproperty
  a_oscsu_count: assert property (p_oscsu_count) else $error("start-up count cut short");

  // start-up count runs only in a crystal mode
  property p_oscsu_crystal;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    $rose(state_r == rst_seq_pkg::ST_OSCSU) |-> $past(isCrystal);
  endproperty
  a_oscsu_crystal: assert property (p_oscsu_crystal) else $error("start-up count in rc mode");

  // lock wait only with the pll enabled
  property p_pll_enabled;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    $rose(state_r == rst_seq_pkg::ST_PLLWAIT) |-> $past(cfg_r.pllEn);
  endproperty
  a_pll_enabled: assert property (p_pll_enabled) else $error("lock wait without pll");

  // brown-out entered only when enabled
  property p_brn_enable;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    $rose(state_r == rst_seq_pkg::ST_BROWN) |-> $past(cfg_r.brnEn);
  endproperty
  a_brn_enable: assert property (p_brn_enable) else $error("brown-out while disabled");

  // a one-cycle dip never trips
  property p_brn_short;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (!belowS ##1 belowS ##1 !belowS) |-> !brnTrip;
  endproperty
  a_brn_short: assert property (p_brn_short) else $error("short dip tripped");

  // brown-out holds while the supply stays low
  property p_brn_hold;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r == rst_seq_pkg::ST_BROWN && belowS && cfg_r.brnEn && !porS)
      |=> state_r == rst_seq_pkg::ST_BROWN ##1 chipReset;
  endproperty
  a_brn_hold: assert property (p_brn_hold) else $error("brown-out left early");

  // dip during the delay returns to brown-out
  property p_pwrup_dip;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r == rst_seq_pkg::ST_PWRUP && cfg_r.brnEn && belowS && !porS)
      |=> state_r == rst_seq_pkg::ST_BROWN;
  endproperty
  a_pwrup_dip: assert property (p_pwrup_dip) else $error("delay not restarted");

  // rc mode with no delay and no pll runs right after power-on
  property p_no_timeout;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r == rst_seq_pkg::ST_POR && !porS && !brnTrip && !cfg_r.pwrupEn &&
     !isCrystal && !cfg_r.pllEn) |=> state_r == rst_seq_pkg::ST_RUN;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("unexpected time-out");

  // releasing the pin after expiry frees the chip on the next edge
  property p_master_clear_pin_release;
    @(posedge clk_sys) disable iff (!rstSync_b_r)
    (state_r == rst_seq_pkg::ST_RUN && !mclrLow) |=> !chipReset;
  endproperty
  a_master_clear_pin_release: assert property (p_master_clear_pin_release) else $error("release delayed");

endmodule : reset_timeout_sequencer
`default_nettype wire

// [common/rst_seq_cfg.svh]
// Purpose: constants of the reset and start-up time-out sequencer
// Assumes: 50 MHz system clock, byte addresses on the register bus
// Notes:   included by bare name; definitions only
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

// register byte offsets
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h4
`define ADDR_FLAG 4'h8

// control fields
`define CTRL_PWRUP_BIT 0
`define CTRL_BRN_BIT 1
`define CTRL_PLL_BIT 2
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 5

// status fields
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 2
`define STAT_CHIPRST_BIT 4
`define STAT_BELOW_BIT 5
`define STAT_MCLEAR_BIT 6

// sticky cause flags, write one to clear
`define FLAG_POR_BIT 0
`define FLAG_BRN_BIT 1
`define FLAG_MCLEAR_BIT 2

// control reset values
`define RST_PWRUP_EN 1'b1
`define RST_BRN_EN 1'b1
`define RST_PLL_EN 1'b0
`define RST_OSC_MODE 2'h2

// timing
`define CLK_MHZ 50
`define PWRUP_TIME_US 10000
`define PLL_TIME_US 2000
`define OSCSU_CYCLES 1024
`define BRN_MIN_TIME_US 100

`endif

// [common/rst_seq_pkg.sv]
// Purpose: shared types of the reset sequencer
// Assumes: constants live in rst_seq_cfg.svh
// Notes:   types only
package rst_seq_pkg;

  // oscillator selection, in register encoding order
  typedef enum logic [1:0] {
    OSC_RESCAP,
    OSC_LOWPWR,
    OSC_MEDXTAL,
    OSC_HIGHXTAL
  } osc_mode_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_PWRUP,
    ST_OSCSU,
    ST_PLLWAIT,
    ST_BROWN,
    ST_RUN,
    ST_SLEEP
  } seq_state_t;

  // configuration settings
  typedef struct packed {
    logic      pwrupEn;
    logic      brnEn;
    logic      pllEn;
    osc_mode_t oscMode;
  } cfg_t;

endpackage : rst_seq_pkg

// [verilog/sync_2ff.sv]
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to clk
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // chain of two flops, cleared under reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : sync_2ff
`default_nettype wire

// [verilog/stage_timer.sv]
// Purpose: shared up-counter for one time-out stage
// Assumes: clear pulses on each stage change
// Notes:   done is combinational, held while count sits at limit
`timescale 1ns/1ps
`default_nettype none
module stage_timer #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // control
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_r;

  if (W < 2) begin : g_bad_width
    $error("stage_timer width too small");
  end

  // saturates at limit so done stays until cleared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (tick && !done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = (cnt_r >= limit);

endmodule : stage_timer
`default_nettype wire

// [testbench/supply_pin_model.sv]
// Purpose: supply monitor and master clear pin seen from outside the sequencer
// Assumes: bench changes its levels right after clk edges
// Notes:   oscillator pin runs at a quarter of clk_sys
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
  // bench controls
  input  wire logic clk,
  input  wire logic powerOn,
  input  wire logic dip,
  input  wire logic mclrLow,
  input  wire logic oscEn,
  // device pins
  output logic      porPulse,
  output logic      supplyBelow,
  output logic      masterClearPin_b,
  output var logic  oscInputPin
);
  logic [2:0] porCnt_r = 3'h0;
  logic       lastOn_r = 1'b0;
  // four-cycle pulse on every supply rise, no parts on the pin
  always_ff @(posedge clk) begin
    lastOn_r <= powerOn;
    if (powerOn && !lastOn_r) porCnt_r <= 3'h4;
    else if (porCnt_r != 3'h0) porCnt_r <= porCnt_r - 3'h1;
  end
  // held until the counter is loaded, so no gap opens on the rise
  assign porPulse         = (porCnt_r != 3'h0) || !powerOn || !lastOn_r;
  assign supplyBelow      = !powerOn || dip;
  assign masterClearPin_b = !mclrLow;
  // stopped crystal sits low so the start-up count cannot creep on
  initial oscInputPin = 1'b0;
  always #40 oscInputPin = oscEn ? !oscInputPin : 1'b0;
endmodule : supply_pin_model
`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench of the reset time-out sequencer
// Assumes: short stage counts set through parameters
// Notes:   tolerance on windows covers oscillator phase and pin sync
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PW = 20;
  localparam int PL = 10;
  localparam int OS = 8;
  logic        clk_sys, rst_b, avs_read, avs_write, powerOn, dip, mclrLow, oscEn, sleepReq, wakeReq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, rdData;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, chipReset, porPulse, supplyBelow, mclrPin_b, oscPin, execHold;
  int          errCount = 0;
  int          nTests = 0;
  logic [31:0] cfgs [6] = '{32'h23, 32'h02, 32'h22, 32'h12, 32'h32, 32'h27};
  int          base [6] = '{PW+4*OS, 0, 4*OS, 4*OS, 4*OS, PW+4*OS+PL};

  reset_timeout_sequencer #(.PWRUP_CYC(PW), .PLL_CYC(PL), .BRN_CYC(4), .OSCSU_CYC(OS)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .porPulse(porPulse),
    .supplyBelow(supplyBelow), .masterClearPin_b(mclrPin_b), .oscInputPin(oscPin),
    .sleepReq(sleepReq), .wakeReq(wakeReq), .chipReset(chipReset), .execHold(execHold));
  supply_pin_model u_far (
    .clk(clk_sys), .powerOn(powerOn), .dip(dip), .mclrLow(mclrLow), .oscEn(oscEn),
    .porPulse(porPulse), .supplyBelow(supplyBelow), .masterClearPin_b(mclrPin_b),
    .oscInputPin(oscPin));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic completeRun();
    if (errCount == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : completeRun

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : ticks

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      errCount++;
      completeRun();
    end
    @(posedge clk_sys);
  endtask : bus

  // drop supply, check reset, raise it again
  task automatic powerCycle(input logic [31:0] ctrl);
    bus(1'b1, 4'h0, ctrl);
    powerOn <= 1'b0;
    // two sync edges, one state edge, one output edge, then sampled
    ticks(5);
    check(chipReset, 1'b1);
    check(execHold, 1'b1);
    powerOn <= 1'b1;
  endtask : powerCycle

  // edges until chipReset falls must land in the window
  task automatic waitRelease(input int lo, input int hi);
    int n;
    n = 0;
    while (chipReset !== 1'b0 && n <= hi) begin
      @(posedge clk_sys);
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask : waitRelease

  task automatic scRegs();
    bus(1'b0, 4'h0, 32'h0);
    check(rdData, 32'h23);
    bus(1'b0, 4'hc, 32'h0);
    check(rdData, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check(rdData[0], 1'b1);
    bus(1'b1, 4'h8, 32'h7);
    bus(1'b0, 4'h8, 32'h0);
    check(rdData, 32'h0);
  endtask : scRegs

  // every mode without delay or pll; medium crystal also with delay, and with delay and pll
  task automatic scTimeouts();
    for (int i = 0; i < 6; i++) begin
      powerCycle(cfgs[i]);
      waitRelease(base[i], base[i] + 20);
    end
    oscEn <= 1'b0;
    powerCycle(32'h22);
    ticks(60);
    check(chipReset, 1'b1);
    oscEn <= 1'b1;
    waitRelease(0, 40);
  endtask : scTimeouts

  // pin low past every time-out, then immediate start
  task automatic scMclr();
    mclrLow <= 1'b1;
    powerCycle(32'h23);
    ticks(100);
    check(chipReset, 1'b1);
    bus(1'b0, 4'h4, 32'h0);
    check(rdData[2:0], rst_seq_pkg::ST_RUN);
    mclrLow <= 1'b0;
    waitRelease(1, 4);
    check(execHold, 1'b0);
  endtask : scMclr

  task automatic scBrown();
    dip <= 1'b1;
    ticks(2);
    dip <= 1'b0;
    ticks(8);
    check(chipReset, 1'b0);
    dip <= 1'b1;
    ticks(12);
    check(chipReset, 1'b1);
    dip <= 1'b0;
    ticks(10);
    dip <= 1'b1;
    ticks(12);
    dip <= 1'b0;
    waitRelease(PW, PW + 12);
    bus(1'b0, 4'h8, 32'h0);
    check(rdData[1], 1'b1);
    bus(1'b1, 4'h0, 32'h21);
    dip <= 1'b1;
    ticks(12);
    dip <= 1'b0;
    check(chipReset, 1'b0);
  endtask : scBrown

  // sleep, then wake in a crystal mode: start-up count holds execution only
  task automatic scSleep();
    int n;
    n = 0;
    sleepReq <= 1'b1;
    ticks(1);
    sleepReq <= 1'b0;
    ticks(2);
    check(execHold, 1'b1);
    wakeReq <= 1'b1;
    ticks(1);
    wakeReq <= 1'b0;
    ticks(3);
    check(chipReset, 1'b0);
    bus(1'b0, 4'h4, 32'h0);
    check(rdData[2:0], rst_seq_pkg::ST_OSCSU);
    while (execHold !== 1'b0 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    check(n >= 4*OS - 16 && n < 60, 1'b1);
  endtask : scSleep

  initial begin
    {avs_read, avs_write, dip, mclrLow, rst_b, sleepReq, wakeReq} = 7'h0;
    {powerOn, oscEn} = 2'h3;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    ticks(8);
    rst_b <= 1'b1;
    ticks(3);
    scRegs();
    scTimeouts();
    scMclr();
    scBrown();
    scSleep();
    completeRun();
  end
endmodule : tb
`default_nettype wire
